// File: pkg/sevq_cfg.svh
// register offsets, field positions, reset values and codes of the event reporter
`ifndef SEVQ_CFG_SVH
`define SEVQ_CFG_SVH
`define SEVQ_OFF_CTRL 12'h000
`define SEVQ_OFF_SUBMASK 12'h004
`define SEVQ_OFF_INFO_SIZE 12'h008
`define SEVQ_OFF_INT_STS 12'h00C
`define SEVQ_OFF_INT_MASK 12'h010
`define SEVQ_OFF_STATUS 12'h014
`define SEVQ_CTRL_HOTPLUG 0
`define SEVQ_CTRL_LEGACY 1
`define SEVQ_CTRL_GUEST_BE 2
`define SEVQ_CTRL_THROTTLE 3
`define SEVQ_CTRL_RST 4'h0
`define SEVQ_SUBMASK_RST 32'h0000_0000
`define SEVQ_INFO_SIZE_RST 16'h0010
`define SEVQ_INT_RETURNED 0
`define SEVQ_INT_LOST 1
`define SEVQ_INT_REFUSED 2
`define SEVQ_INT_SHORT 3
`define SEVQ_INT_RST 4'h0
`define SEVQ_T_NO_EVENT 31'h0000_0000
`define SEVQ_T_TRANSPORT_RESET 31'h0000_0001
`define SEVQ_T_NOTIFY 31'h0000_0002
`define SEVQ_T_PARAM 31'h0000_0003
`define SEVQ_LOST_BIT 31
`define SEVQ_RSN_UNIT_RESET_PRESENT 32'h0000_0000
`define SEVQ_RSN_UNIT_APPEARED 32'h0000_0001
`define SEVQ_RSN_UNIT_GONE 32'h0000_0002
`define SEVQ_PERIPH_MMC 5'h05
`define SEVQ_KEY_ILLEGAL 4'h5
`define SEVQ_KEY_UNIT_ATTN 4'h6
`define SEVQ_ASC_GONE 8'h25
`define SEVQ_ASC_RESET 8'h29
`define SEVQ_ASC_APPEARED 8'h3F
`define SEVQ_ASCQ_APPEARED 8'h0E
`define SEVQ_REC_BYTES 16'h0010
`define SEVQ_LUN_UNIT_LO 16
`endif

// File: pkg/sevq_pkg.sv
// types shared by the event reporter modules
package sevq_pkg;
  typedef enum logic [1:0] {
    SEVQ_KIND_RESET,
    SEVQ_KIND_NOTIFY,
    SEVQ_KIND_PARAM,
    SEVQ_KIND_BAD
  } sevq_kind_t;
  typedef enum logic [1:0] {
    SEVQ_IDLE,
    SEVQ_WRITE,
    SEVQ_RETURN
  } sevq_state_t;
endpackage

// File: hdl/sevq_word.sv
// selects one 32-bit word of an event record and applies guest byte order
`timescale 1ns/1ps
`include "sevq_cfg.svh"
module sevq_word (
  // record fields
  input wire logic [1:0] idx,
  input wire logic [31:0] rec_type,
  input wire logic [63:0] rec_lun,
  input wire logic [31:0] rec_reason,
  input wire logic swap,
  // selected word
  output logic [31:0] word
);
  function automatic logic [31:0] bswap(input logic [31:0] w);
    bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // lun is a byte array, so it is never swapped; only the two integer words are
  always_comb begin
    unique case (idx)
      2'h0: word = swap ? bswap(rec_type) : rec_type;
      2'h1: word = rec_lun[31:0];
      2'h2: word = rec_lun[63:32];
      2'h3: word = swap ? bswap(rec_reason) : rec_reason;
    endcase
  end
endmodule

// File: hdl/sevq_sense.sv
// maps an accepted event onto its equivalent sense key and codes
`timescale 1ns/1ps
`include "sevq_cfg.svh"
module sevq_sense
  import sevq_pkg::*;
(
  // event
  input wire sevq_pkg::sevq_kind_t kind,
  input wire logic [31:0] reason,
  input wire logic [7:0] asc_in,
  input wire logic [7:0] ascq_in,
  // sense
  output logic has_sense,
  output logic [3:0] key,
  output logic [7:0] asc,
  output logic [7:0] ascq
);
  always_comb begin
    has_sense = 1'b0;
    key = 4'h0;
    asc = 8'h00;
    ascq = 8'h00;
    if (kind == SEVQ_KIND_RESET) begin
      has_sense = 1'b1;
      if (reason == `SEVQ_RSN_UNIT_GONE) begin
        key = `SEVQ_KEY_ILLEGAL;
        asc = `SEVQ_ASC_GONE;
      end else if (reason == `SEVQ_RSN_UNIT_APPEARED) begin
        key = `SEVQ_KEY_UNIT_ATTN;
        asc = `SEVQ_ASC_APPEARED;
        ascq = `SEVQ_ASCQ_APPEARED;
      end else begin
        key = `SEVQ_KEY_UNIT_ATTN;
        asc = `SEVQ_ASC_RESET;
      end
    end else if (kind == SEVQ_KIND_PARAM) begin
      // unit attention carries the same codes as the event
      has_sense = 1'b1;
      key = `SEVQ_KEY_UNIT_ATTN;
      asc = asc_in;
      ascq = ascq_in;
    end
  end
endmodule

// File: hdl/sevq_top.sv
// event queue reporter of a virtual SCSI host adapter, with APB registers
// Summary of operation
// - unit reset, appearance or removal writes a type 1 record with lun and reason.
// - reset reason is 0 reset-present, 1 appeared, 2 gone.
// - gone and appeared reasons are refused unless hot plug was negotiated.
// - gone or appeared for unit 0 may cover the whole target.
// - reset events also give sense: 5/25/00, 6/29, 6/3F/0E.
// - notify writes type 2, lun and reason limited to subscribed events.
// - parameter change writes type 3, asc in bits 7:0, ascq in 15:8.
// - parameter change also raises unit attention with the same codes.
// - no parameter change event for units of peripheral type 5.
// - lost events set bit 31 of the type word, maybe in a no-event record.
// - legacy mode writes integer fields in guest native byte order.
// - events are not queued; with no buffer they drop, or throttle stalls them.
// - a buffer shorter than the advertised size is used at once with type 0.
`timescale 1ns/1ps
`include "sevq_cfg.svh"
module sevq_top
  import sevq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event source
  input wire logic evt_valid,
  input wire sevq_pkg::sevq_kind_t evt_kind,
  input wire logic [63:0] evt_lun,
  input wire logic [31:0] evt_reason,
  input wire logic [7:0] evt_asc,
  input wire logic [7:0] evt_ascq,
  input wire logic [4:0] evt_periph,
  output logic evt_ready,
  // posted event buffers
  input wire logic buf_valid,
  input wire logic [15:0] buf_len,
  output logic buf_ready,
  // record write and buffer return
  output logic wr_valid,
  output logic [1:0] wr_idx,
  output logic [31:0] wr_data,
  output logic ret_valid,
  output logic [15:0] ret_len,
  // sense reflection
  output logic sense_valid,
  output logic [3:0] sense_key,
  output logic [7:0] sense_asc,
  output logic [7:0] sense_ascq,
  output logic [63:0] sense_lun,
  output logic sense_whole_target,
  // interrupt
  output logic irq
);
  import sevq_pkg::*;

  logic [3:0] ctrl_reg, ctrl_next;
  logic [31:0] submask_reg, submask_next;
  logic [15:0] info_reg, info_next;
  logic [3:0] ists_reg, ists_next;
  logic [3:0] imask_reg, imask_next;
  logic [15:0] drops_reg, drops_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg;
  sevq_state_t state_reg, state_next;
  logic [1:0] cnt_reg, cnt_next;
  logic lost_reg, lost_next, have_buf_reg, have_buf_next;
  logic [31:0] rec_type_reg, rec_type_next, rec_reason_reg, rec_reason_next;
  logic [63:0] rec_lun_reg, rec_lun_next;
  logic evt_ready_reg, buf_ready_reg, wr_valid_reg, ret_valid_reg;
  logic [1:0] wr_idx_reg;
  logic [31:0] wr_data_reg, word;
  logic sense_valid_reg, sense_whole_reg;
  logic [3:0] sense_key_reg;
  logic [7:0] sense_asc_reg, sense_ascq_reg;
  logic [63:0] sense_lun_reg;
  logic has_sense;
  logic [3:0] s_key;
  logic [7:0] s_asc, s_ascq;
  logic evt_take, buf_take, short_buf, avail, refuse, ok_evt, drop, load;
  logic [31:0] evt_word_reason, notify_reason;
  logic [3:0] ev;
  logic apb_wr, apb_rd;

  // apb: one wait state, so every answer comes from a flop
  assign apb_wr = psel & penable & pready_reg & pwrite;
  assign apb_rd = psel & penable & ~pready_reg & ~pwrite;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `SEVQ_OFF_CTRL) || (a == `SEVQ_OFF_SUBMASK) ||
             (a == `SEVQ_OFF_INFO_SIZE) || (a == `SEVQ_OFF_INT_STS) ||
             (a == `SEVQ_OFF_INT_MASK) || (a == `SEVQ_OFF_STATUS);
  endfunction

  // event and buffer acceptance
  assign evt_take = evt_valid & evt_ready_reg;
  assign buf_take = buf_valid & buf_ready_reg;
  assign short_buf = buf_take & (buf_len < info_reg);
  assign avail = have_buf_reg | (buf_take & ~short_buf);
  assign notify_reason = evt_reason & submask_reg;

  // events that the rules forbid are refused, never counted as lost
  always_comb begin
    refuse = 1'b0;
    evt_word_reason = evt_reason;
    unique case (evt_kind)
      SEVQ_KIND_RESET: begin
        if (evt_reason > `SEVQ_RSN_UNIT_GONE) begin
          refuse = 1'b1;
        end
        if (!ctrl_reg[`SEVQ_CTRL_HOTPLUG] && evt_reason != `SEVQ_RSN_UNIT_RESET_PRESENT) begin
          refuse = 1'b1;
        end
      end
      SEVQ_KIND_NOTIFY: begin
        evt_word_reason = notify_reason;
        refuse = (notify_reason == 32'h0000_0000);
      end
      SEVQ_KIND_PARAM: begin
        evt_word_reason = {16'h0000, evt_ascq, evt_asc};
        refuse = (evt_periph == `SEVQ_PERIPH_MMC);
      end
      SEVQ_KIND_BAD: refuse = 1'b1;
    endcase
  end
  assign ok_evt = evt_take & ~refuse;

  sevq_sense u_sense (
    .kind(evt_kind),
    .reason(evt_reason),
    .asc_in(evt_asc),
    .ascq_in(evt_ascq),
    .has_sense(has_sense),
    .key(s_key),
    .asc(s_asc),
    .ascq(s_ascq)
  );

  sevq_word u_word (
    .idx(cnt_reg),
    .rec_type(rec_type_reg),
    .rec_lun(rec_lun_reg),
    .rec_reason(rec_reason_reg),
    .swap(ctrl_reg[`SEVQ_CTRL_LEGACY] & ctrl_reg[`SEVQ_CTRL_GUEST_BE]),
    .word(word)
  );

  // record engine: no internal queue, one buffer held at most
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    lost_next = lost_reg;
    have_buf_next = avail;
    rec_type_next = rec_type_reg;
    rec_lun_next = rec_lun_reg;
    rec_reason_next = rec_reason_reg;
    drop = 1'b0;
    load = 1'b0;
    unique case (state_reg)
      SEVQ_IDLE: begin
        if (short_buf) begin
          // short buffer consumed now; a same-cycle event is lost into it
          load = 1'b1;
          rec_type_next = {lost_reg | ok_evt, `SEVQ_T_NO_EVENT};
          rec_lun_next = 64'h0;
          rec_reason_next = 32'h0;
          drop = ok_evt;
        end else if (ok_evt && avail) begin
          load = 1'b1;
          unique case (evt_kind)
            SEVQ_KIND_RESET: rec_type_next = {lost_reg, `SEVQ_T_TRANSPORT_RESET};
            SEVQ_KIND_NOTIFY: rec_type_next = {lost_reg, `SEVQ_T_NOTIFY};
            default: rec_type_next = {lost_reg, `SEVQ_T_PARAM};
          endcase
          rec_lun_next = evt_lun;
          rec_reason_next = evt_word_reason;
        end else if (ok_evt) begin
          drop = 1'b1;
          lost_next = 1'b1;
        end else if (avail && lost_reg) begin
          load = 1'b1;
          rec_type_next = {1'b1, `SEVQ_T_NO_EVENT};
          rec_lun_next = 64'h0;
          rec_reason_next = 32'h0;
        end
        if (load) begin
          state_next = SEVQ_WRITE;
          cnt_next = 2'h0;
          lost_next = 1'b0;
          have_buf_next = 1'b0;
        end
      end
      SEVQ_WRITE: begin
        // four words in record order, then hand the buffer back
        cnt_next = cnt_reg + 2'h1;
        if (cnt_reg == 2'h3) begin
          state_next = SEVQ_RETURN;
        end
      end
      SEVQ_RETURN: state_next = SEVQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SEVQ_IDLE;
      cnt_reg <= 2'h0;
      lost_reg <= 1'b0;
      have_buf_reg <= 1'b0;
      rec_type_reg <= 32'h0000_0000;
      rec_lun_reg <= 64'h0000_0000_0000_0000;
      rec_reason_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      lost_reg <= lost_next;
      have_buf_reg <= have_buf_next;
      rec_type_reg <= rec_type_next;
      rec_lun_reg <= rec_lun_next;
      rec_reason_reg <= rec_reason_next;
    end
  end

  // registers; hardware set wins over the w1c clear
  assign ev = {short_buf, evt_take & refuse, drop, state_reg == SEVQ_RETURN};
  always_comb begin
    ctrl_next = ctrl_reg;
    submask_next = submask_reg;
    info_next = info_reg;
    imask_next = imask_reg;
    ists_next = ists_reg;
    drops_next = drop ? drops_reg + 16'h0001 : drops_reg;
    prdata_next = 32'h0000_0000;
    pready_next = psel & penable & ~pready_reg;
    pslverr_next = psel & penable & ~pready_reg & ~mapped(paddr);
    if (apb_wr) begin
      unique case (paddr)
        `SEVQ_OFF_CTRL: ctrl_next = pwdata[3:0];
        `SEVQ_OFF_SUBMASK: submask_next = pwdata;
        `SEVQ_OFF_INFO_SIZE: info_next = pwdata[15:0];
        `SEVQ_OFF_INT_STS: ists_next = ists_reg & ~pwdata[3:0];
        `SEVQ_OFF_INT_MASK: imask_next = pwdata[3:0];
        default: ;
      endcase
    end
    ists_next = ists_next | ev;
    if (apb_rd) begin
      unique case (paddr)
        `SEVQ_OFF_CTRL: prdata_next = {28'h0, ctrl_reg};
        `SEVQ_OFF_SUBMASK: prdata_next = submask_reg;
        `SEVQ_OFF_INFO_SIZE: prdata_next = {16'h0, info_reg};
        `SEVQ_OFF_INT_STS: prdata_next = {28'h0, ists_reg};
        `SEVQ_OFF_INT_MASK: prdata_next = {28'h0, imask_reg};
        `SEVQ_OFF_STATUS: prdata_next = {drops_reg, 13'h0, state_reg != SEVQ_IDLE,
                                         have_buf_reg, lost_reg};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SEVQ_CTRL_RST;
      submask_reg <= `SEVQ_SUBMASK_RST;
      info_reg <= `SEVQ_INFO_SIZE_RST;
      ists_reg <= `SEVQ_INT_RST;
      imask_reg <= `SEVQ_INT_RST;
      drops_reg <= 16'h0000;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      submask_reg <= submask_next;
      info_reg <= info_next;
      ists_reg <= ists_next;
      imask_reg <= imask_next;
      drops_reg <= drops_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg <= |(ists_next & imask_next);
    end
  end

  // port flops; ready looks one state ahead so no take lands mid-record
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_ready_reg <= 1'b0;
      buf_ready_reg <= 1'b0;
      wr_valid_reg <= 1'b0;
      wr_idx_reg <= 2'h0;
      wr_data_reg <= 32'h0000_0000;
      ret_valid_reg <= 1'b0;
      sense_valid_reg <= 1'b0;
      sense_key_reg <= 4'h0;
      sense_asc_reg <= 8'h00;
      sense_ascq_reg <= 8'h00;
      sense_lun_reg <= 64'h0000_0000_0000_0000;
      sense_whole_reg <= 1'b0;
    end else begin
      evt_ready_reg <= (state_next == SEVQ_IDLE) &
                       ~(ctrl_next[`SEVQ_CTRL_THROTTLE] & ~have_buf_next);
      buf_ready_reg <= (state_next == SEVQ_IDLE) & ~have_buf_next;
      wr_valid_reg <= (state_reg == SEVQ_WRITE);
      wr_idx_reg <= cnt_reg;
      wr_data_reg <= word;
      ret_valid_reg <= (state_reg == SEVQ_RETURN);
      sense_valid_reg <= ok_evt & has_sense;
      sense_key_reg <= s_key;
      sense_asc_reg <= s_asc;
      sense_ascq_reg <= s_ascq;
      sense_lun_reg <= evt_lun;
      // unit 0 gone or appeared is widened to the whole target
      sense_whole_reg <= (evt_kind == SEVQ_KIND_RESET) &
                         (evt_reason != `SEVQ_RSN_UNIT_RESET_PRESENT) &
                         (evt_lun[`SEVQ_LUN_UNIT_LO +: 16] == 16'h0000);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign evt_ready = evt_ready_reg;
  assign buf_ready = buf_ready_reg;
  assign wr_valid = wr_valid_reg;
  assign wr_idx = wr_idx_reg;
  assign wr_data = wr_data_reg;
  assign ret_valid = ret_valid_reg;
  assign ret_len = `SEVQ_REC_BYTES;
  assign sense_valid = sense_valid_reg;
  assign sense_key = sense_key_reg;
  assign sense_asc = sense_asc_reg;
  assign sense_ascq = sense_ascq_reg;
  assign sense_lun = sense_lun_reg;
  assign sense_whole_target = sense_whole_reg;
  assign irq = irq_reg;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_WORD_ORDER: assert property (wr_valid_reg && wr_idx_reg == 2'h0 |=>
    wr_idx_reg == 2'h1 ##1 wr_idx_reg == 2'h2 ##1 wr_idx_reg == 2'h3 ##1 ret_valid_reg)
    else $error("record words out of order");
  AST_RET_AFTER_LAST: assert property (ret_valid_reg |->
    $past(wr_valid_reg) && $past(wr_idx_reg) == 2'h3)
    else $error("buffer returned before last word");
  AST_RESET_REASON: assert property (state_reg == SEVQ_WRITE &&
    rec_type_reg[30:0] == `SEVQ_T_TRANSPORT_RESET |-> rec_reason_reg <= `SEVQ_RSN_UNIT_GONE)
    else $error("reset reason out of range");
  AST_HOTPLUG: assert property (evt_take && evt_kind == SEVQ_KIND_RESET &&
    evt_reason != `SEVQ_RSN_UNIT_RESET_PRESENT && !ctrl_reg[`SEVQ_CTRL_HOTPLUG]
    |=> ists_reg[`SEVQ_INT_REFUSED] && state_reg == SEVQ_IDLE)
    else $error("hot plug reason sent without feature");
  AST_NOTIFY_MASK: assert property (ok_evt && avail && evt_kind == SEVQ_KIND_NOTIFY
    |=> (rec_reason_reg & ~$past(submask_reg)) == 32'h0 && rec_type_reg[30:0] == `SEVQ_T_NOTIFY)
    else $error("notify reason outside subscription");
  AST_PARAM_FIELDS: assert property (ok_evt && avail && !short_buf &&
    evt_kind == SEVQ_KIND_PARAM |=> rec_reason_reg == {16'h0, $past(evt_ascq), $past(evt_asc)})
    else $error("param change reason misplaced");
  AST_MMC: assert property (evt_take && evt_kind == SEVQ_KIND_PARAM &&
    evt_periph == `SEVQ_PERIPH_MMC |=> !sense_valid_reg && ists_reg[`SEVQ_INT_REFUSED])
    else $error("param change sent for multimedia unit");
  AST_LOST_FLAG: assert property (drop && !short_buf |=> lost_reg ##1
    (lost_reg || rec_type_reg[`SEVQ_LOST_BIT]))
    else $error("lost event not flagged");
  AST_SHORT_BUF: assert property (short_buf && state_reg == SEVQ_IDLE |=>
    state_reg == SEVQ_WRITE && rec_type_reg[30:0] == `SEVQ_T_NO_EVENT ##5 ret_valid_reg)
    else $error("short buffer not consumed as no-event");
  AST_SENSE_GONE: assert property (sense_valid_reg && sense_key_reg == `SEVQ_KEY_ILLEGAL
    |-> sense_asc_reg == `SEVQ_ASC_GONE && sense_ascq_reg == 8'h00)
    else $error("removal sense codes wrong");
  COV_RESET_REC: cover property (ok_evt && evt_kind == SEVQ_KIND_RESET ##6 ret_valid_reg);
  COV_DROP_THEN_FLAG: cover property (drop ##[1:20] wr_valid_reg && rec_type_reg[31]);
  COV_SHORT: cover property (short_buf);
  COV_IRQ: cover property (irq_reg);
endmodule

// File: dv/sevq_drv_model.sv
// partner model: guest driver posting event buffers
`timescale 1ns/1ps
module sevq_drv_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // post request from bench
  input wire logic post,
  input wire logic [15:0] len,
  // buffer handshake
  input wire logic buf_ready,
  output logic buf_valid,
  output logic [15:0] buf_len
);
  // hold each posted device-writable buffer until the device takes it
  // one descriptor per buffer; command framing never rides this path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_valid <= 1'b0;
      buf_len <= 16'hFFFF;
    end else if (post) begin
      buf_valid <= 1'b1;
      buf_len <= len;
    end else if (buf_valid && buf_ready) begin
      buf_valid <= 1'b0;
      buf_len <= ~buf_len; // released length must not look still valid
    end
  end
endmodule

// File: dv/sevq_top_tb_top.sv
// self-checking bench of the event queue reporter
`timescale 1ns/1ps
`include "sevq_cfg.svh"
module sevq_top_tb_top;
  import sevq_pkg::*;
  localparam logic [63:0] LUN = 64'h0807_0605_0000_0A01;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic evt_valid = 1'b0, evt_ready, buf_valid, buf_ready, post = 1'b0;
  sevq_kind_t evt_kind = SEVQ_KIND_RESET;
  logic [63:0] evt_lun = 64'h0;
  logic [31:0] evt_reason = 32'h0;
  logic [7:0] evt_asc = 8'h00, evt_ascq = 8'h00;
  logic [4:0] evt_periph = 5'h00;
  logic [15:0] buf_len, ret_len, plen = 16'h0010;
  logic wr_valid, ret_valid, sense_valid, sense_whole_target, irq;
  logic [1:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] sense_key;
  logic [7:0] sense_asc, sense_ascq;
  logic [63:0] sense_lun;
  logic [31:0] rec [0:3];
  logic [20:0] sen;
  logic [63:0] slun;
  int nret = 0, n0, num_errors = 0, n_tests = 0;

  always #5 pclk = ~pclk;

  sevq_drv_model drv_u (.pclk(pclk), .presetn(presetn), .post(post), .len(plen),
    .buf_ready(buf_ready), .buf_valid(buf_valid), .buf_len(buf_len));

  sevq_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt_valid(evt_valid), .evt_kind(evt_kind), .evt_lun(evt_lun),
    .evt_reason(evt_reason), .evt_asc(evt_asc), .evt_ascq(evt_ascq),
    .evt_periph(evt_periph), .evt_ready(evt_ready), .buf_valid(buf_valid),
    .buf_len(buf_len), .buf_ready(buf_ready), .wr_valid(wr_valid), .wr_idx(wr_idx),
    .wr_data(wr_data), .ret_valid(ret_valid), .ret_len(ret_len),
    .sense_valid(sense_valid), .sense_key(sense_key), .sense_asc(sense_asc),
    .sense_ascq(sense_ascq), .sense_lun(sense_lun),
    .sense_whole_target(sense_whole_target), .irq(irq));

  // collect record words, returns and sense as the device emits them
  always @(posedge pclk) begin
    if (wr_valid) rec[wr_idx] <= wr_data;
    if (ret_valid) nret <= nret + 1;
    if (sense_valid) sen <= {sense_whole_target, sense_key, sense_asc, sense_ascq};
    if (sense_valid) slun <= sense_lun;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    $display("BAD at %0t: handshake never answered", $time);
    results();
  endtask

  // apb transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic post_buf(input logic [15:0] l);
    n0 = nret;
    @(posedge pclk);
    plen <= l;
    post <= 1'b1;
    @(posedge pclk);
    post <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask

  // offer one event until taken, then let the record walk finish
  task automatic send(input sevq_kind_t k, input logic [31:0] r, input logic [4:0] p);
    int i;
    n0 = nret;
    @(posedge pclk);
    evt_kind <= k;
    evt_lun <= LUN;
    evt_reason <= r;
    evt_asc <= r[7:0];
    evt_ascq <= r[15:8];
    evt_periph <= p;
    evt_valid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (evt_ready === 1'b1) break;
    end
    if (i == 50) hang();
    evt_valid <= 1'b0;
    evt_lun <= ~LUN;
    repeat (10) @(posedge pclk);
  endtask

  task automatic chk_rec(input logic [31:0] t, input logic [31:0] r);
    chk(rec[0], t);
    chk(rec[1], LUN[31:0]);
    chk(rec[2], LUN[63:32]);
    chk(rec[3], r);
    chk(ret_len, `SEVQ_REC_BYTES);
    chk(nret - n0, 1);
  endtask

  initial begin
    logic [20:0] exp_sen [0:2];
    exp_sen[0] = {1'b0, `SEVQ_KEY_UNIT_ATTN, `SEVQ_ASC_RESET, 8'h00};
    exp_sen[1] = {1'b1, `SEVQ_KEY_UNIT_ATTN, `SEVQ_ASC_APPEARED, `SEVQ_ASCQ_APPEARED};
    exp_sen[2] = {1'b1, `SEVQ_KEY_ILLEGAL, `SEVQ_ASC_GONE, 8'h00};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SEVQ_OFF_INFO_SIZE, 32'h0);
    chk(rd, 32'h0000_0010);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(err, 1'b1);
    $display("test registers done");
    // every reset reason with hot plug negotiated
    apb(1'b1, `SEVQ_OFF_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      post_buf(16'h0010);
      send(SEVQ_KIND_RESET, i, 5'h00);
      chk_rec(32'h1, i);
      chk(sen[19:8], exp_sen[i][19:8]);
      if (i > 0) chk(sen, exp_sen[i]);
      chk(slun, LUN);
      if (i > 0) chk(rec[1][31:16] == 16'h0000, sen[20]);
    end
    $display("test transport reset done");
    post_buf(16'h0010);
    send(SEVQ_KIND_PARAM, 32'h0000_092A, 5'h00);
    chk_rec(32'h3, 32'h0000_092A);
    chk(sen[19:0], {`SEVQ_KEY_UNIT_ATTN, 16'h2A09});
    apb(1'b1, `SEVQ_OFF_INT_STS, 32'hF);
    post_buf(16'h0010);
    send(SEVQ_KIND_PARAM, 32'h0000_092A, `SEVQ_PERIPH_MMC);
    chk(nret - n0, 0);
    apb(1'b0, `SEVQ_OFF_INT_STS, 32'h0);
    chk(rd[2], 1'b1);
    apb(1'b1, `SEVQ_OFF_SUBMASK, 32'h10);
    send(SEVQ_KIND_NOTIFY, 32'h14, 5'h00);
    chk_rec(32'h2, 32'h10);
    $display("test param and notify done");
    apb(1'b1, `SEVQ_OFF_CTRL, 32'h0);
    post_buf(16'h0010);
    send(SEVQ_KIND_RESET, 32'h1, 5'h00);
    chk(nret - n0, 0);
    apb(1'b1, `SEVQ_OFF_CTRL, 32'h6);
    send(SEVQ_KIND_NOTIFY, 32'h10, 5'h00);
    chk_rec(32'h0200_0000, 32'h1000_0000);
    $display("test hot plug and byte order done");
    // no buffer held: the event drops and raises the lost interrupt
    apb(1'b1, `SEVQ_OFF_CTRL, 32'h0);
    apb(1'b1, `SEVQ_OFF_INT_STS, 32'hF);
    apb(1'b1, `SEVQ_OFF_INT_MASK, 32'h2);
    send(SEVQ_KIND_RESET, 32'h0, 5'h00);
    chk(nret - n0, 0);
    chk(irq, 1'b1);
    apb(1'b1, `SEVQ_OFF_INT_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, `SEVQ_OFF_INT_MASK, 32'h2);
    apb(1'b1, `SEVQ_OFF_INT_STS, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    post_buf(16'h0010);
    chk(rec[0], 32'h8000_0000);
    chk(nret - n0, 1);
    // driver answers the lost flag by polling the status word
    apb(1'b0, `SEVQ_OFF_STATUS, 32'h0);
    chk(rd, 32'h0001_0000);
    $display("test lost events done");
    // throttle with no buffer holds the event off instead of dropping it
    apb(1'b1, `SEVQ_OFF_CTRL, 32'h8);
    repeat (2) @(posedge pclk);
    chk(evt_ready, 1'b0);
    post_buf(16'h0010);
    send(SEVQ_KIND_RESET, 32'h0, 5'h00);
    chk_rec(32'h1, 32'h0);
    apb(1'b1, `SEVQ_OFF_CTRL, 32'h0);
    $display("test throttle done");
    // short buffer relative to a larger advertised size
    apb(1'b1, `SEVQ_OFF_INFO_SIZE, 32'h20);
    post_buf(16'h0010);
    chk(rec[0], 32'h0);
    chk(nret - n0, 1);
    $display("test short buffer done");
    results();
  end
endmodule
